// ==== rtl/serial_mem_pkg.sv ====
package serial_mem_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 11;
  localparam int          MEM_DEPTH = 2048;
  localparam logic [10:0] ADDR_RST  = 11'h000;
  localparam logic [10:0] ADDR_STEP = 11'h001;

  // ----------------------------------------------------------------
  // Slave address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  DEV_TYPE  = 4'ha;
  localparam int          TYPE_MSB  = 7;
  localparam int          TYPE_LSB  = 4;
  localparam int          PAGE_MSB  = 3;
  localparam int          PAGE_LSB  = 1;
  localparam int          RW_BIT    = 0;

  // ----------------------------------------------------------------
  // Bit counting
  // ----------------------------------------------------------------
  localparam logic [3:0]  CNT_RST   = 4'h0;
  localparam logic [3:0]  CNT_ONE   = 4'h1;
  localparam logic [3:0]  CNT_LAST  = 4'h7;
  localparam logic [3:0]  CNT_FULL  = 4'h8;
  localparam logic [7:0]  BYTE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Pin synchroniser, bit order {wp, sda, scl}; idle bus reads high
  // ----------------------------------------------------------------
  localparam int          PIN_W     = 3;
  localparam int          PIN_SCL   = 0;
  localparam int          PIN_SDA   = 1;
  localparam int          PIN_WP    = 2;
  localparam logic [2:0]  SYNC_RST  = 3'h3;
  localparam logic        SDA_LOW   = 1'b0;

  // ----------------------------------------------------------------
  // Port sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_DEV_ADDR  = 4'h1,
    ST_DEV_ACK   = 4'h2,
    ST_WORD_ADDR = 4'h3,
    ST_WORD_ACK  = 4'h4,
    ST_WR_DATA   = 4'h5,
    ST_WR_ACK    = 4'h6,
    ST_RD_DATA   = 4'h7,
    ST_RD_ACK    = 4'h8,
    ST_IGNORE    = 4'h9
  } port_state_e;

endpackage

// ==== rtl/pin_sync_if.sv ====
`timescale 1ns/100ps
interface pin_sync_if;
  import serial_mem_pkg::*;

  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] synced;

  // Sampler takes raw pins, core reads the synchronised copy
  modport sampler (input raw, output synced);
  modport core    (output raw, input synced);
endinterface

// ==== rtl/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync
  import serial_mem_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  pin_sync_if.sampler pins
);

  logic [PIN_W-1:0] meta_reg;
  logic [PIN_W-1:0] hold_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= SYNC_RST;
      hold_reg <= SYNC_RST;
    end else begin
      meta_reg <= pins.raw;
      hold_reg <= meta_reg;
    end
  end

  assign pins.synced = hold_reg;

endmodule

// ==== rtl/serial_mem_port.sv ====
// Functional notes
// R1 - STOP during any operation aborts it and returns to idle.
// R2 - START at any time aborts and awaits a new slave address byte.
// R3 - Master keeps data stable while clock high, except START/STOP.
// R4 - Transmitter releases data on ninth clock so receiver can acknowledge.
// R5 - No low data during acknowledge clock means no-acknowledge; operation aborts.
// R6 - Master withholds acknowledge on last wanted read byte.
// R7 - First byte after START is the slave address; device is slave only.
// R8 - Respond only when upper four address bits hold the device type.
// R9 - Address bits three to one select a 256-byte page, top address bits.
// R10 - Address bit zero: one is read, zero is write.
// R11 - In writes, next byte is low eight bits; loads full 11-bit latch.
// R12 - Reads send no word address; new page plus held low eight bits.
// R13 - Address latch increments after each data byte, before its acknowledge.
// R14 - Address latch wraps from highest location to zero.
// R15 - No limit on consecutive bytes in one operation.
// R16 - Read: eight bits out, sample acknowledge, continue or end.
// R17 - Write: eight bits in, then device drives acknowledge.
// R18 - Every byte travels most significant bit first.
// R19 - Array written after eighth bit, before acknowledge; earlier abort keeps memory.
// R20 - No write delay; device always ready straight after a write.
// R21 - Write-protect high: no data acknowledge and no address increment.
// R22 - Write-protect low enables writes; unconnected input counts as unprotected.
// R23 - Sample data on clock rise, change outgoing data after clock fall.
// R24 - Random read: write address, word address, repeated START, read address.
// R25 - Wrong device type: no acknowledge, data released until next START.
// R26 - Synchronise clock and data; detect START/STOP from data edges.
`timescale 1ns/100ps
module serial_mem_port
  import serial_mem_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic wp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pin_sync_if              pins ();

  logic [7:0]              mem [MEM_DEPTH];
  port_state_e             state_reg;
  port_state_e             state_next;
  logic [3:0]              cnt_reg;
  logic [3:0]              cnt_next;
  logic [7:0]              shift_reg;
  logic [7:0]              shift_next;
  logic [7:0]              tx_reg;
  logic [7:0]              tx_next;
  logic [ADDR_W-1:0]       addr_reg;
  logic [ADDR_W-1:0]       addr_next;
  logic                    oe_reg;
  logic                    oe_next;
  logic                    rw_reg;
  logic                    rw_next;
  logic                    nack_reg;
  logic                    nack_next;
  logic                    scl_d_reg;
  logic                    sda_d_reg;

  wire                     scl_s;
  wire                     sda_s;
  wire                     wp_s;
  wire                     scl_rise;
  wire                     scl_fall;
  wire                     start_det;
  wire                     stop_det;
  wire                     byte_full;
  wire                     last_rise;
  wire  [7:0]              byte_in;
  wire  [7:0]              mem_rd;
  wire                     type_match;
  wire                     mem_we;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  assign pins.raw = {wp, sda_in, scl_in};

  pin_sync u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pins    (pins.sampler)
  );

  assign scl_s = pins.synced[PIN_SCL];
  assign sda_s = pins.synced[PIN_SDA];
  // Undriven pin is taken low by the pad pull-down, so writes are open
  assign wp_s  = pins.synced[PIN_WP];                       // R22

  // ----------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------
  // Delayed copies read only the second synchroniser stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Clock edges and bus conditions, all mutually exclusive
  assign scl_rise  = scl_s & ~scl_d_reg;                    // R23
  assign scl_fall  = ~scl_s & scl_d_reg;                    // R23
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // R26
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // R26

  // ----------------------------------------------------------------
  // Byte assembly and decoding
  // ----------------------------------------------------------------
  // Incoming bits shift in from the bottom, so the first is the MSB
  assign byte_in    = {shift_reg[6:0], sda_s};              // R18
  assign byte_full  = (cnt_reg == CNT_FULL);
  assign last_rise  = scl_rise & (cnt_reg == CNT_LAST);
  assign type_match = (shift_reg[TYPE_MSB:TYPE_LSB] == DEV_TYPE); // R8
  assign mem_rd     = mem[addr_reg];

  // Commit on the fall ending bit eight, so a START in that clock still aborts
  assign mem_we = (state_reg == ST_WR_DATA) & scl_fall & byte_full & ~wp_s; // R19

  // ----------------------------------------------------------------
  // Byte array
  // ----------------------------------------------------------------
  // No reset: contents are meant to persist; no page buffer either
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[addr_reg] <= shift_reg;                           // R19
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    addr_next  = addr_reg;
    oe_next    = oe_reg;
    rw_next    = rw_reg;
    nack_next  = nack_reg;
    // Sampling on every rise; only byte states use the result
    if (scl_rise) begin
      shift_next = byte_in;                                 // R23
      cnt_next   = cnt_reg + CNT_ONE;
    end
    unique case (state_reg)
      ST_DEV_ADDR: begin
        // First byte after START is always the slave address
        if (scl_fall && byte_full) begin                    // R7
          if (type_match) begin
            oe_next    = 1'b1;                              // R20
            state_next = ST_DEV_ACK;
            rw_next    = shift_reg[RW_BIT];                 // R10
            addr_next  = {shift_reg[PAGE_MSB:PAGE_LSB], addr_reg[7:0]}; // R9 R12
          end else begin
            state_next = ST_IGNORE;                         // R25
          end
        end
      end
      ST_DEV_ACK: begin
        if (scl_fall) begin
          cnt_next = CNT_RST;
          if (rw_reg) begin
            tx_next    = mem_rd;
            oe_next    = ~mem_rd[7];                        // R18
            state_next = ST_RD_DATA;
          end else begin
            oe_next    = 1'b0;                              // R4
            state_next = ST_WORD_ADDR;
          end
        end
      end
      ST_WORD_ADDR: begin
        if (scl_fall && byte_full) begin
          addr_next[7:0] = shift_reg;                       // R11
          oe_next        = 1'b1;                            // R17
          state_next     = ST_WORD_ACK;
        end
      end
      ST_WORD_ACK: begin
        if (scl_fall) begin
          oe_next    = 1'b0;                                // R4
          cnt_next   = CNT_RST;
          state_next = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        // Protected writes leave the latch where it was
        if (scl_fall && byte_full) begin
          if (!wp_s) begin
            addr_next = addr_reg + ADDR_STEP;               // R13 R14
          end
          oe_next    = ~wp_s;                               // R17 R21
          state_next = ST_WR_ACK;
        end
      end
      ST_WR_ACK: begin
        if (scl_fall) begin
          oe_next    = 1'b0;                                // R4
          cnt_next   = CNT_RST;
          // Unbounded run of bytes; only a refusal ends it here
          state_next = wp_s ? ST_IGNORE : ST_WR_DATA;       // R15 R21
        end
      end
      ST_RD_DATA: begin
        if (last_rise) begin
          addr_next = addr_reg + ADDR_STEP;                 // R13 R14
        end
        if (scl_fall) begin
          if (byte_full) begin
            oe_next    = 1'b0;                              // R4
            state_next = ST_RD_ACK;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};                  // R18
            oe_next = ~tx_reg[6];                           // R23
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise) begin
          nack_next = sda_s;                                // R16
        end
        if (scl_fall) begin
          cnt_next = CNT_RST;
          if (nack_reg) begin
            state_next = ST_IGNORE;                         // R5 R16
          end else begin
            // Acknowledged: next byte goes out straight away
            tx_next    = mem_rd;                            // R6 R15
            oe_next    = ~mem_rd[7];
            state_next = ST_RD_DATA;
          end
        end
      end
      ST_IDLE, ST_IGNORE: begin
        oe_next = 1'b0;                                     // R25
      end
      default: begin
        oe_next    = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
    // Bus conditions override whatever the byte logic chose
    if (start_det) begin
      state_next = ST_DEV_ADDR;                             // R2 R24
      cnt_next   = CNT_RST;
      oe_next    = 1'b0;
    end
    if (stop_det) begin
      state_next = ST_IDLE;                                 // R1
      oe_next    = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_RST;
      shift_reg <= BYTE_RST;
      tx_reg    <= BYTE_RST;
      addr_reg  <= ADDR_RST;
      oe_reg    <= 1'b0;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      addr_reg  <= addr_next;
      oe_reg    <= oe_next;
      rw_reg    <= rw_next;
      nack_reg  <= nack_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low, enable carries the data
  assign sda_out = SDA_LOW;
  assign sda_oe  = oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_addr_byte_done;
    (state_reg == ST_DEV_ADDR) && byte_full && scl_fall;
  endsequence

  sequence s_wr_last_bit;
    (state_reg == ST_WR_DATA) && byte_full && scl_fall;
  endsequence

  property p_stop_idle;
    @(posedge ref_clk) disable iff (!nrst)
      stop_det |=> (state_reg == ST_IDLE) && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // R1
    else $error("STOP did not return the port to idle");

  property p_start_addr;
    @(posedge ref_clk) disable iff (!nrst)
      start_det |=> (state_reg == ST_DEV_ADDR) && (cnt_reg == CNT_RST) && !sda_oe;
  endproperty
  a_start_addr: assert property (p_start_addr) // R2
    else $error("START did not rearm slave address reception");

  property p_type_reject;
    @(posedge ref_clk) disable iff (!nrst)
      s_addr_byte_done and (shift_reg[7:4] != DEV_TYPE) |=>
        (state_reg == ST_IGNORE) && !sda_oe;
  endproperty
  a_type_reject: assert property (p_type_reject) // R25
    else $error("Foreign device type was acknowledged");

  property p_page_load;
    @(posedge ref_clk) disable iff (!nrst)
      s_addr_byte_done and type_match |=>
        sda_oe && (addr_reg[10:8] == $past(shift_reg[3:1]))
        && (addr_reg[7:0] == $past(addr_reg[7:0]));
  endproperty
  a_page_load: assert property (p_page_load) // R9
    else $error("Page select not loaded into address latch");

  property p_write_inc;
    @(posedge ref_clk) disable iff (!nrst)
      s_wr_last_bit and !wp_s |=>
        (addr_reg == $past(addr_reg) + ADDR_STEP) && (mem[$past(addr_reg)] == $past(shift_reg));
  endproperty
  a_write_inc: assert property (p_write_inc) // R13
    else $error("Write did not store byte and advance address");

  property p_wp_hold;
    @(posedge ref_clk) disable iff (!nrst)
      s_wr_last_bit and wp_s |=> $stable(addr_reg);
  endproperty
  a_wp_hold: assert property (p_wp_hold) // R21
    else $error("Address moved on a protected write");

  property p_wp_noack;
    @(posedge ref_clk) disable iff (!nrst)
      (state_reg == ST_WR_ACK) && wp_s |-> !sda_oe;
  endproperty
  a_wp_noack: assert property (p_wp_noack) // R21
    else $error("Protected write byte was acknowledged");

  property p_nack_end;
    @(posedge ref_clk) disable iff (!nrst)
      (state_reg == ST_RD_ACK) && nack_reg && scl_fall |=>
        (state_reg == ST_IGNORE) ##1 !sda_oe;
  endproperty
  a_nack_end: assert property (p_nack_end) // R5
    else $error("Read continued after no-acknowledge");

  property p_drive_on_fall;
    @(posedge ref_clk) disable iff (!nrst)
      $changed(sda_oe) |-> $past(scl_fall || start_det || stop_det);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) // R23
    else $error("Data line drive changed outside a clock fall");

  property p_release_ninth;
    @(posedge ref_clk) disable iff (!nrst)
      (state_reg == ST_RD_DATA) && byte_full && scl_fall |=>
        (state_reg == ST_RD_ACK) && !sda_oe;
  endproperty
  a_release_ninth: assert property (p_release_ninth) // R4
    else $error("Data line not released for master acknowledge");

endmodule

// ==== bench/i2c_master_model.sv ====
`timescale 1ns/100ps
module i2c_master_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ----------------------------------------------------------------
  // Bus master: clock phases of 4 ref_clk, pull-up holds released data
  // ----------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One bit; data changes only mid-low, sampled at end of high
  task automatic bit_cycle(input logic b, output logic got);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    got = sda;
    scl <= 1'b0;
    tick(2);
  endtask

  // Slow START: long release before clock rise, so no stray STOP is aimed at
  task automatic start();
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // Partial byte, most significant bit first
  task automatic wr_bits(input logic [7:0] d, input int n);
    logic g;
    for (int i = 7; i > 7 - n; i--) begin
      bit_cycle(d[i], g);
    end
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic g;
    wr_bits(d, 8);
    bit_cycle(1'b1, g);
    ack = ~g;
  endtask

  // Acknowledge withheld on the last byte wanted
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, g);
      d[i] = g;
    end
    bit_cycle(~ack, g);
  endtask
endmodule

// ==== bench/i2c_slave_serial_memory_port_test.sv ====
`timescale 1ns/100ps
module i2c_slave_serial_memory_port_test
  import serial_mem_pkg::*;
;

  logic       ref_clk;
  logic       nrst;
  logic       wp;
  logic       scl;
  logic       m_low;
  logic       sda_out;
  logic       sda_oe;
  logic       sda_line;
  int         n_mismatch;
  int         num_checks;

  // ----------------------------------------------------------------
  // Open-drain wire: pull-up, either party may pull low
  // ----------------------------------------------------------------
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~m_low;

  serial_mem_port u_serial_mem_port (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .scl_in  (scl),
    .sda_in  (sda_line),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wp      (wp)
  );

  i2c_master_model u_i2c_master_model (
    .ref_clk (ref_clk),
    .sda     (sda_line),
    .scl     (scl),
    .sda_low (m_low)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_i2c_master_model.wr_byte(d, a);
    chk({7'h0, a}, {7'h0, exp_ack});
  endtask

  task automatic rd(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    u_i2c_master_model.rd_byte(ack, d);
    chk(d, exp);
  endtask

  // Write address byte plus word address loads the full latch
  task automatic set_addr(input logic [10:0] a);
    u_i2c_master_model.start();
    wr({DEV_TYPE, a[10:8], 1'b0}, 1'b1);
    wr(a[7:0], 1'b1);
  endtask

  task automatic rd_start(input logic [2:0] page);
    u_i2c_master_model.start();
    wr({DEV_TYPE, page, 1'b1}, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Burst write then random read straight after, no polling delay
  task automatic s_seq();
    set_addr(11'h3fd);
    wr(8'h5a, 1'b1);
    wr(8'ha5, 1'b1);
    wr(8'h3c, 1'b1);
    u_i2c_master_model.stop();
    set_addr(11'h3fd);
    rd_start(3'h3);
    rd(1'b1, 8'h5a);
    rd(1'b1, 8'ha5);
    rd(1'b0, 8'h3c);
    rd(1'b0, 8'hff);
    u_i2c_master_model.stop();
  endtask

  // Latch wraps from the top location to zero
  task automatic s_wrap();
    set_addr(11'h7ff);
    wr(8'h81, 1'b1);
    wr(8'h7e, 1'b1);
    set_addr(11'h7ff);
    rd_start(3'h7);
    rd(1'b1, 8'h81);
    rd(1'b0, 8'h7e);
    u_i2c_master_model.stop();
  endtask

  // Foreign device types stay unanswered, later bytes too
  task automatic s_bad_type();
    logic [7:0] t [2];
    t = '{8'hb4, 8'h21};
    foreach (t[i]) begin
      u_i2c_master_model.start();
      wr(t[i], 1'b0);
      wr(8'h00, 1'b0);
      u_i2c_master_model.stop();
    end
  endtask

  // Protected write: no ack, memory and latch left alone
  task automatic s_protect();
    set_addr(11'h123);
    wr(8'h66, 1'b1);
    u_i2c_master_model.stop();
    wp <= 1'b1;
    u_i2c_master_model.tick(4);
    set_addr(11'h123);
    wr(8'h99, 1'b0);
    rd_start(3'h1);
    rd(1'b0, 8'h66);
    u_i2c_master_model.stop();
    wp <= 1'b0;
    u_i2c_master_model.tick(4);
  endtask

  // Aborts before the eighth bit leave the array unchanged
  task automatic s_abort();
    set_addr(11'h200);
    wr(8'h11, 1'b1);
    u_i2c_master_model.stop();
    set_addr(11'h200);
    u_i2c_master_model.wr_bits(8'hee, 4);
    u_i2c_master_model.stop();
    set_addr(11'h200);
    u_i2c_master_model.wr_bits(8'hee, 7);
    rd_start(3'h2);
    rd(1'b0, 8'h11);
    u_i2c_master_model.stop();
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    nrst       = 1'b0;
    wp         = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    s_seq();
    s_wrap();
    s_bad_type();
    s_protect();
    s_abort();
    end_of_test();
  end
endmodule
